// ### hdl/rsn_cpu_end.sv
/*
  Processor end: toggles its clock activity output while running, ignores
  maskable interrupts, halts on the non-maskable one.
  Assumes the supervisor end drives reset and nmi on the shared link.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rsn_consts.svh"
module rsn_cpu_end
  import rsn_pkg::*;
#(
  parameter int DIV = `RSN_CPU_CLOCK_ACTIVITY_OUT_DIV
)
(
  input  wire logic ref_clk,      // System clock
  input  wire logic resetn,       // Async reset, low active
  input  wire logic clock_stop,   // Models a stopped processor clock
  rsn_link_if.cpu   link,         // Link to the supervisor
  output logic      running,      // Out of reset and not halted
  output logic      halted        // Halted by the non-maskable interrupt
);
  import rsn_pkg::*;

  initial if (DIV < 2 || DIV > 15) $error("rsn_cpu_end: DIV out of range");

  rsn_cpu_state_t state_q;
  logic [`RSN_DIV_W-1:0] div_q;
  logic clk_out_q;
  logic halted_q;
  logic irq_seen;

  wire div_end = (div_q == `RSN_DIV_W'(DIV - 1));
  wire active  = (state_q == RSN_CPU_RUN) && !halted_q && !clock_stop;
  // Maskable inputs are kept disabled
  assign irq_seen = 1'b0 & |link.maskable_irq;

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q   <= RSN_CPU_RESET;
      div_q     <= '0;
      clk_out_q <= 1'b0;
      halted_q  <= 1'b0;
    end
    else if (!link.supervisor_reset_n)
    begin
      state_q   <= RSN_CPU_RESET;
      div_q     <= '0;
      clk_out_q <= 1'b0;
      halted_q  <= 1'b0;
    end
    else
    begin
      state_q <= RSN_CPU_RUN;
      if (link.nmi || irq_seen)
        halted_q <= 1'b1;
      if (active)
      begin
        div_q <= div_end ? '0 : div_q + `RSN_DIV_W'(1);
        if (div_end)
          clk_out_q <= ~clk_out_q;
      end
    end
  end

  assign link.cpu_clock_activity_out = clk_out_q;
  assign running = (state_q == RSN_CPU_RUN) && !halted_q;
  assign halted  = halted_q;
endmodule
`default_nettype wire

// ### hdl/rsn_supervisor.sv
/*
  Reset supervisor: holds processor reset on low supply, manual switch and
  stalled processor clock, stretches release, and drives the halt request.
  Assumes supply_ok, supply_drop, the switch and the jumper are synchronous
  to ref_clk and already debounced.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rsn_consts.svh"
// What this block does
// - Hold reset while supply below valid level
// - Hold reset 350 ms after supply good
// - Assert reset on significant supply fall
// - Processor supplies clock activity pulse train
// - Reset after 50 ms without clock activity
// - Manual switch press asserts reset
// - Hold reset 350 ms after switch release
// - Processor keeps five maskable interrupts disabled
// - Watchdog timeout drives halting non-maskable interrupt
// - Fitted calibration jumper suppresses the interrupt
// - Absent jumper: latch drives interrupt high
// - Leave jumper out in normal operation
module rsn_supervisor
  import rsn_pkg::*;
#(
  parameter int HOLD_CYC  = `RSN_HOLD_CYC,
  parameter int STALL_CYC = `RSN_STALL_CYC
)
(
  input  wire logic ref_clk,                        // System clock
  input  wire logic resetn,                         // Async reset, low active
  input  wire logic supply_ok,                      // Logic rail above 4.5 V
  input  wire logic supply_drop,                    // Significant rail fall seen
  input  wire logic manual_reset_switch,            // Pressed when high
  input  wire logic calibration_nmi_disable_jumper, // Fitted when high
  input  wire logic watchdog_timeout,               // Watchdog expiry pulse
  rsn_link_if.sup   link,                           // Link to the processor
  output logic      reset_active,                   // Reset held, from register
  output logic      stall_reset                     // Last reset from clock stall
);
  import rsn_pkg::*;

  initial
  begin
    if (HOLD_CYC < 1 || HOLD_CYC >= (1 << `RSN_CNT_W))
      $error("rsn_supervisor: HOLD_CYC out of range");
    if (STALL_CYC < 2 || STALL_CYC >= (1 << `RSN_CNT_W))
      $error("rsn_supervisor: STALL_CYC out of range");
    if ($bits(link.maskable_irq) != `RSN_IRQ_LINES)
      $error("rsn_supervisor: interrupt line count mismatch");
  end

  rsn_state_t                state_q;
  rsn_state_t                state_d;
  logic [`RSN_CNT_W-1:0]     hold_q;
  logic [`RSN_CNT_W-1:0]     hold_d;
  logic [`RSN_CNT_W-1:0]     stall_q;
  logic [`RSN_CNT_W-1:0]     stall_d;
  logic                      act_q;
  logic                      halt_request_latch_q;
  logic                      halt_request_latch_d;
  logic                      stall_flag_q;
  logic                      stall_flag_d;
  logic [`RSN_IRQ_LINES-1:0] irq_off;

  // Cause decode; any one of them pulls reset low at once
  wire                  supply_cause = !supply_ok || supply_drop;
  wire                  switch_cause = manual_reset_switch;
  wire                  stalled      = (stall_q == `RSN_CNT_W'(STALL_CYC - 1));
  wire                  cause        = supply_cause || switch_cause || stalled;
  wire                  in_run       = (state_q == RSN_ST_RUN);
  wire                  hold_done    = (hold_q == `RSN_CNT_W'(HOLD_CYC - 1));
  wire                  activity     = (link.cpu_clock_activity_out != act_q);
  wire                  watch_clear  = !in_run || activity || stalled;
  wire                  halt_set     = watchdog_timeout && in_run;
  wire                  flag_clear   = supply_cause || switch_cause;
  wire                  reset_out_n  = in_run && !cause;
  wire [`RSN_CNT_W-1:0] hold_inc     = hold_q + `RSN_CNT_W'(1);
  wire [`RSN_CNT_W-1:0] stall_inc    = stall_q + `RSN_CNT_W'(1);

  // Stretch counter restarts on every new cause
  always_comb
  begin
    state_d = state_q;
    hold_d  = hold_q;
    if (cause)
    begin
      state_d = RSN_ST_HOLD;
      hold_d  = '0;
    end
    else
    begin
      unique case (state_q)
        RSN_ST_HOLD:
        begin
          hold_d = hold_inc;
          if (hold_done)
            state_d = RSN_ST_RUN;
        end
        RSN_ST_RUN:
        begin
          hold_d = hold_q;
        end
        default:
        begin
          state_d = RSN_ST_HOLD;
          hold_d  = '0;
        end
      endcase
    end
  end

  // Clock activity watch, only while the processor runs
  always_comb
  begin
    stall_d = stall_inc;
    if (watch_clear)
      stall_d = '0;
  end

  // Stall marker kept until a supply or switch cause
  always_comb
  begin
    stall_flag_d = stall_flag_q;
    if (stalled)
      stall_flag_d = 1'b1;
    else if (flag_clear)
      stall_flag_d = 1'b0;
  end

  // Halt request latch, cleared only by processor reset
  always_comb
  begin
    halt_request_latch_d = halt_request_latch_q;
    if (halt_set)
      halt_request_latch_d = 1'b1;
    else if (!in_run)
      halt_request_latch_d = 1'b0;
  end

  // Hold or run state
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      state_q <= RSN_ST_HOLD;
    else
      state_q <= state_d;
  end

  // Release stretch count
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      hold_q <= '0;
    else
      hold_q <= hold_d;
  end

  // Cycles without processor clock activity
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      stall_q <= '0;
    else
      stall_q <= stall_d;
  end

  // Last seen level of the activity toggle
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      act_q <= 1'b0;
    else
      act_q <= link.cpu_clock_activity_out;
  end

  // Stall marker
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      stall_flag_q <= 1'b0;
    else
      stall_flag_q <= stall_flag_d;
  end

  // Halt request
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      halt_request_latch_q <= 1'b0;
    else
      halt_request_latch_q <= halt_request_latch_d;
  end

  // Every maskable line is held inactive
  generate
    for (genvar g = 0; g < `RSN_IRQ_LINES; g++)
    begin : g_irq_off
      assign irq_off[g] = 1'b0;
    end
  endgenerate

  // Reset asserts combinationally on a cause, without waiting for a clock
  assign link.supervisor_reset_n = reset_out_n;
  assign link.nmi = halt_request_latch_q && !calibration_nmi_disable_jumper;
  assign link.maskable_irq = irq_off;
  assign reset_active = !in_run;
  assign stall_reset  = stall_flag_q;
endmodule
`default_nettype wire

// ### shared/rsn_consts.svh
/*
  Timing and width constants for the reset supervisor and its processor end.
  Assumes a 200 MHz ref_clk; times are given in their own unit.
*/
`ifndef RSN_CONSTS_SVH
`define RSN_CONSTS_SVH

`define RSN_CLK_MHZ         200
`define RSN_HOLD_MS         350
`define RSN_CLK_STALL_MS    50
`define RSN_CYC_PER_MS      (`RSN_CLK_MHZ * 1000)
`define RSN_HOLD_CYC        (`RSN_HOLD_MS * `RSN_CYC_PER_MS)
`define RSN_STALL_CYC       (`RSN_CLK_STALL_MS * `RSN_CYC_PER_MS)
`define RSN_CNT_W           27
`define RSN_IRQ_LINES       5
`define RSN_CPU_CLOCK_ACTIVITY_OUT_DIV      4
`define RSN_DIV_W           4

`endif

// ### shared/rsn_link_if.sv
/*
  Link between the supervisor and the processor end.
  Assumes both ends run on the same ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rsn_consts.svh"
interface rsn_link_if;
  logic                      supervisor_reset_n;
  logic                      nmi;
  logic                      cpu_clock_activity_out;
  logic [`RSN_IRQ_LINES-1:0] maskable_irq;

  modport sup
  (
    output supervisor_reset_n,
    output nmi,
    output maskable_irq,
    input  cpu_clock_activity_out
  );

  modport cpu
  (
    input  supervisor_reset_n,
    input  nmi,
    input  maskable_irq,
    output cpu_clock_activity_out
  );
endinterface
`default_nettype wire

// ### shared/rsn_pkg.sv
/*
  Types shared by both ends of the reset supervisor link.
  Assumes rsn_consts.svh is on the include path.
*/
`default_nettype none
package rsn_pkg;
  typedef enum logic [1:0] {
    RSN_ST_HOLD = 2'b00,
    RSN_ST_RUN  = 2'b01
  } rsn_state_t;

  typedef enum logic [0:0] {
    RSN_CPU_RESET = 1'b0,
    RSN_CPU_RUN   = 1'b1
  } rsn_cpu_state_t;
endpackage
`default_nettype wire

// ### tb/reset_supervisor_nmi_control_tb.sv
/* Bench joining supervisor and processor ends over the link.
   Assumes shortened hold and stall counts set below. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fails++; \
  $display("ERROR %0t got %0h want %0h", $time, a, b); end end
module reset_supervisor_nmi_control_tb;
  localparam int HOLD  = 20;
  localparam int STALL = 40;
  logic ref_clk = 1'b0;
  logic resetn  = 1'b0;
  logic sup_ok  = 1'b0;
  logic drop    = 1'b0;
  logic sw      = 1'b0;
  logic jmp     = 1'b0;
  logic wdt     = 1'b0;
  logic stop    = 1'b0;
  logic act;
  logic stall_rst;
  logic running;
  logic halted;
  int   fails = 0;
  int   num_checks = 0;
  int   n;
  rsn_link_if link();
  rsn_supervisor #(.HOLD_CYC(HOLD), .STALL_CYC(STALL)) rsn_supervisor_inst (.ref_clk(ref_clk),
    .resetn(resetn), .supply_ok(sup_ok), .supply_drop(drop), .manual_reset_switch(sw),
    .calibration_nmi_disable_jumper(jmp), .watchdog_timeout(wdt), .link(link.sup),
    .reset_active(act), .stall_reset(stall_rst));
  rsn_cpu_end rsn_cpu_end_inst (.ref_clk(ref_clk), .resetn(resetn), .clock_stop(stop),
    .link(link.cpu), .running(running), .halted(halted));
  rsn_link_chk #(.HOLD_CYC(HOLD), .STALL_CYC(STALL)) rsn_link_chk_inst (.ref_clk(ref_clk),
    .resetn(resetn), .supervisor_reset_n(link.supervisor_reset_n), .nmi(link.nmi),
    .cpu_clock_activity_out(link.cpu_clock_activity_out), .maskable_irq(link.maskable_irq));
  always #2.5 ref_clk = ~ref_clk;
  task automatic end_of_test;
    $display("checks %0d errors %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  // Edges until reset_n reaches the wanted level
  task automatic wait_lvl(input logic lvl, output int k);
    k = 0;
    while (link.supervisor_reset_n !== lvl)
    begin
      cyc(1);
      k++;
      if (k > 300)
      begin
        fails++;
        end_of_test();
      end
    end
  endtask
  initial
  begin
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
    cyc(30);
    `CHK(link.supervisor_reset_n, 1'b0)
    `CHK(act, 1'b1)
    @(posedge ref_clk);
    sup_ok <= 1'b1;
    wait_lvl(1'b1, n);
    `CHK(n, HOLD)
    cyc(12);
    `CHK(running, 1'b1)
    `CHK(act, 1'b0)
    @(posedge ref_clk);
    sw <= 1'b1;
    #1 `CHK(link.supervisor_reset_n, 1'b0)
    cyc(5);
    @(posedge ref_clk);
    sw <= 1'b0;
    cyc(10);
    @(posedge ref_clk);
    sw <= 1'b1;
    @(posedge ref_clk);
    sw <= 1'b0;
    wait_lvl(1'b1, n);
    `CHK(n, HOLD)
    cyc(12);
    @(posedge ref_clk);
    drop <= 1'b1;
    #1 `CHK(link.supervisor_reset_n, 1'b0)
    @(posedge ref_clk);
    drop <= 1'b0;
    wait_lvl(1'b1, n);
    `CHK(n, HOLD)
    cyc(12);
    @(posedge ref_clk);
    stop <= 1'b1;
    wait_lvl(1'b0, n);
    `CHK(n >= STALL - 1 && n <= STALL + 8, 1'b1)
    cyc(1);
    `CHK(stall_rst, 1'b1)
    @(posedge ref_clk);
    stop <= 1'b0;
    wait_lvl(1'b1, n);
    cyc(12);
    @(posedge ref_clk);
    jmp <= 1'b1;
    wdt <= 1'b1;
    @(posedge ref_clk);
    wdt <= 1'b0;
    cyc(3);
    `CHK(link.nmi, 1'b0)
    `CHK(halted, 1'b0)
    @(posedge ref_clk);
    jmp <= 1'b0;
    #1 `CHK(link.nmi, 1'b1)
    cyc(3);
    `CHK(halted, 1'b1)
    wait_lvl(1'b0, n);
    wait_lvl(1'b1, n);
    `CHK(link.nmi, 1'b0)
    `CHK(link.maskable_irq, 5'h00)
    `CHK(stall_rst, 1'b1)
    cyc(12);
    @(posedge ref_clk);
    sw <= 1'b1;
    @(posedge ref_clk);
    sw <= 1'b0;
    cyc(1);
    `CHK(stall_rst, 1'b0)
    end_of_test();
  end
endmodule
`default_nettype wire

// ### tb/rsn_link_chk.sv
/* Assertions on the supervisor to processor link.
   Assumes one ref_clk and async active-low resetn. */
`timescale 1ns/1ps
`default_nettype none
`include "rsn_consts.svh"
module rsn_link_chk
#(
  parameter int HOLD_CYC  = 20,
  parameter int STALL_CYC = 40
)
(
  input wire logic                      ref_clk,                // Clock
  input wire logic                      resetn,                 // Reset, low active
  input wire logic                      supervisor_reset_n,     // Processor reset
  input wire logic                      nmi,                    // Halt request
  input wire logic                      cpu_clock_activity_out, // Activity toggle
  input wire logic [`RSN_IRQ_LINES-1:0] maskable_irq            // Unused lines
);
  int   low_q   = 0;
  int   still_q = 0;
  logic act_q   = 1'b0;
  wire  moved   = act_q != cpu_clock_activity_out;
  always_ff @(posedge ref_clk)
  begin
    low_q   <= supervisor_reset_n ? 0 : low_q + 1;
    act_q   <= cpu_clock_activity_out;
    still_q <= (!supervisor_reset_n || moved) ? 0 : still_q + 1;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  sequence s_low2;
    !supervisor_reset_n ##1 !supervisor_reset_n;
  endsequence
  a_irq_all_off: assert property (maskable_irq == '0)
    else $error("maskable line active");
  a_hold_counted: assert property ($rose(supervisor_reset_n) |-> low_q >= HOLD_CYC)
    else $error("reset released early");
  a_stall_bound: assert property (still_q < STALL_CYC)
    else $error("stalled clock not reset");
  a_nmi_cleared: assert property (s_low2 ##1 !supervisor_reset_n |-> !nmi)
    else $error("halt request kept in reset");
  a_nmi_from_run: assert property ($rose(nmi) |-> $past(supervisor_reset_n))
    else $error("halt request outside run");
  a_act_reset_idle: assert property (s_low2 ##1 !supervisor_reset_n |-> $stable(cpu_clock_activity_out))
    else $error("activity while in reset");
  a_act_starts: assert property ($rose(supervisor_reset_n) |-> ##[1:12] $changed(cpu_clock_activity_out))
    else $error("no activity after release");
  a_halt_freezes: assert property (nmi [*4] |-> $stable(cpu_clock_activity_out))
    else $error("activity while halted");
endmodule
`default_nettype wire
